// >>> acrs_cfg.svh
// Shared constants of the calibration reset sequencer and its host controller.
// Notes on behaviour
// - Sample code leaves ten sample clocks later.
// - Device holds recalibrate pin low during power-on.
// - Power-on release lets pull-up start calibration.
// - Host keeps sample clock stable during calibration.
// - Host sends no register traffic during power-on.
// - Host leaves serial data line undriven.
// - Every rising recalibrate edge that passes the pin filter starts calibration.
// - Status bit 0 at 0xb6 shows done.
// - Data bus shows 0xcccc while calibrating.
// - Ratio one: output clock always toggles.
// - Ratio two/four: clock low while pin low.
// - Calibration nominal 200ms, host allows 550ms.
// - Host pulses pin low, then releases it.
// - Sample clock runs during every register access.
`ifndef ACRS_CFG_SVH
`define ACRS_CFG_SVH
// ----------------------------------------
// Timing
// ----------------------------------------
`define ACRS_CLK_KHZ        40000
`define ACRS_LATENCY        10
`define ACRS_CAL_NOM_MS     200
`define ACRS_CAL_MAX_MS     550
`define ACRS_CAL_NOM_CYC    (`ACRS_CAL_NOM_MS * `ACRS_CLK_KHZ)
`define ACRS_CAL_MAX_CYC    (`ACRS_CAL_MAX_MS * `ACRS_CLK_KHZ)
`define ACRS_PULSE_CYC      4
// ----------------------------------------
// Device data and register
// ----------------------------------------
`define ACRS_SAMPLE_W       14
`define ACRS_DATA_W         16
`define ACRS_BUSY_CODE      16'hcccc
`define ACRS_STATUS_OFS     8'hb6
`define ACRS_CAL_DONE_BIT   0
// ----------------------------------------
// Host registers
// ----------------------------------------
`define ACRS_REG_CTRL       8'h00
`define ACRS_REG_STATUS     8'h04
`define ACRS_REG_IRQ_STAT   8'h08
`define ACRS_REG_IRQ_MASK   8'h0c
`define ACRS_CTRL_RECAL_BIT 0
`define ACRS_ST_DONE_BIT    0
`define ACRS_ST_FAIL_BIT    1
`define ACRS_ST_BUSY_BIT    2
`define ACRS_ST_PIN_BIT     3
`define ACRS_IRQ_DONE_BIT   0
`define ACRS_IRQ_FAIL_BIT   1
`endif

// >>> acrs_chk.sv
// Concurrent checks on the link between the converter end and its host controller.
`timescale 1ns/100ps
`default_nettype none
`include "acrs_cfg.svh"
module acrs_chk
   import acrs_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        srst,
   input  wire logic        porActive,
   input  wire logic [13:0] sampleIn,
   input  wire acrs_div_t   divSelect,
   input  wire logic        recalHostOe,
   input  wire logic        recalDevOe,
   input  wire logic        recalLevel,
   input  wire logic        outClk,
   input  wire logic [15:0] dataOut,
   input  wire logic        regRdReq,
   input  wire logic [7:0]  regAddr,
   input  wire logic        regRdAck,
   input  wire logic [7:0]  regRdData
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);
   // ----------------------------------------
   // Helper logic
   // ----------------------------------------
   // Counts live data cycles, so the latency check skips a pipeline still filling.
   logic [3:0] doneRun;
   logic [3:0] next_doneRun;
   always_comb begin
      next_doneRun = doneRun;
      if (srst || dataOut == 16'hcccc) begin
         next_doneRun = 4'h0;
      end else if (doneRun != 4'hf) begin
         next_doneRun = doneRun + 4'h1;
      end
   end
   always_ff @(posedge clk) begin
      doneRun <= next_doneRun;
   end
   // ----------------------------------------
   // Properties
   // ----------------------------------------
   sequence s_pulse;
      recalHostOe [*4] ##1 !recalHostOe;
   endsequence
   sequence s_busy_hold;
      ##6 (dataOut == 16'hcccc) [*8];
   endsequence
   property p_por_hold;
      porActive && !srst |=> recalDevOe && !recalLevel;
   endproperty
   a_por_hold: assert property (p_por_hold) else $error("pin not held low");
   property p_por_release;
      $fell(porActive) |=> !recalDevOe;
   endproperty
   a_por_release: assert property (p_por_release) else $error("pin not released");
   property p_cal_code;
      $rose(recalLevel) |-> s_busy_hold;
   endproperty
   a_cal_code: assert property (p_cal_code) else $error("busy code missing");
   property p_latency;
      doneRun >= 4'ha && dataOut != 16'hcccc |-> dataOut == {2'b00, $past(sampleIn, 10)};
   endproperty
   a_latency: assert property (p_latency) else $error("data latency wrong");
   property p_done_bit;
      regRdReq && regAddr == 8'hb6 && dataOut != 16'hcccc |=> regRdAck && regRdData[0];
   endproperty
   a_done_bit: assert property (p_done_bit) else $error("done bit not set");
   property p_no_read;
      regRdReq |-> $past(dataOut) != 16'hcccc;
   endproperty
   a_no_read: assert property (p_no_read) else $error("read during calibration");
   property p_ratio1;
      divSelect == ACRS_DIV_1 && $past(divSelect) == ACRS_DIV_1 |=> outClk != $past(outClk);
   endproperty
   a_ratio1: assert property (p_ratio1) else $error("output clock stalled");
   property p_hold_low;
      (!recalLevel && (divSelect == ACRS_DIV_2 || divSelect == ACRS_DIV_4)) [*6] |-> !outClk;
   endproperty
   a_hold_low: assert property (p_hold_low) else $error("output clock not low");
   property p_div2_cadence;
      divSelect == ACRS_DIV_2 && recalLevel && $rose(outClk) |=> outClk ##1 !outClk;
   endproperty
   a_div2_cadence: assert property (p_div2_cadence) else $error("ratio two cadence");
   property p_pulse;
      $rose(recalHostOe) |-> s_pulse;
   endproperty
   a_pulse: assert property (p_pulse) else $error("recal pulse length");
endmodule // acrs_chk
`default_nettype wire

// >>> acrs_device.sv
// Converter end: calibration sequencing, data pipeline, output clock.
`timescale 1ns/100ps
`default_nettype none
`include "acrs_cfg.svh"
module acrs_device
   import acrs_pkg::*;
#(
   parameter int unsigned CAL_CYCLES = `ACRS_CAL_NOM_CYC,
   parameter int unsigned LATENCY    = `ACRS_LATENCY,
   parameter int unsigned DW         = `ACRS_SAMPLE_W,
   parameter int unsigned OW         = `ACRS_DATA_W
) (
   input  wire logic          clk,
   input  wire logic          srst,
   input  wire logic          porActive,
   input  wire logic [DW-1:0] sampleIn,
   input  wire acrs_div_t     divSelect,
   acrs_link.dev              link
);
   // ----------------------------------------
   // Declarations
   // ----------------------------------------
   logic          pinNow;
   logic          pinPrev;
   logic          next_pinPrev;
   logic          pinRise;
   acrs_dstate_t  devState;
   acrs_dstate_t  next_devState;
   logic [31:0]   calCnt;
   logic [31:0]   next_calCnt;
   logic          calDone;
   logic          next_calDone;
   logic          devOe;
   logic          next_devOe;
   logic [DW-1:0] pipe      [LATENCY-1];
   logic [DW-1:0] next_pipe [LATENCY-1];
   logic [OW-1:0] dataOut;
   logic [OW-1:0] next_dataOut;
   logic          outClk;
   logic          next_outClk;
   logic [1:0]    divCnt;
   logic [1:0]    next_divCnt;
   logic [1:0]    half;
   logic          rdAck;
   logic          next_rdAck;
   logic [7:0]    rdData;
   logic [7:0]    next_rdData;

   assign link.recalDevOe = devOe;
   assign link.outClk     = outClk;
   assign link.dataOut    = dataOut;
   assign link.regRdAck   = rdAck;
   assign link.regRdData  = rdData;

   // ----------------------------------------
   // Recalibrate pin input
   // ----------------------------------------
   // The filter costs a few cycles of lag and drops a one-cycle low pulse.
   // Its reset value is the idle pull-up level, so no false edge follows reset.
   acrs_sync #(
      .RST_VAL (1'b1)
   ) u_pinSync (
      .clk  (clk),
      .srst (srst),
      .din  (link.recalLevel),
      .dout (pinNow)
   );

   assign pinRise = pinNow & ~pinPrev;

   // ----------------------------------------
   // Calibration sequencer
   // ----------------------------------------
   // The done flag survives a pin-low spell on purpose: a late reader still
   // sees the last result until a new run really starts.
   always_comb begin
      next_pinPrev  = pinNow;
      next_devOe    = porActive;
      next_devState = devState;
      next_calCnt   = calCnt;
      next_calDone  = calDone;
      if (!pinNow) begin
         next_devState = ACRS_D_HELD;
         next_calCnt   = 32'h0;
      end else if (pinRise) begin
         next_devState = ACRS_D_CAL;
         next_calCnt   = 32'h0;
         next_calDone  = 1'b0;
      end else begin
         case (devState)
            ACRS_D_CAL: begin
               if (calCnt == 32'(CAL_CYCLES - 1)) begin
                  next_devState = ACRS_D_DONE;
                  next_calDone  = 1'b1;
               end else begin
                  next_calCnt = calCnt + 32'h1;
               end
            end
            default: begin
               next_devState = devState;
            end
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         pinPrev  <= 1'b1;
         devOe    <= 1'b0;
         devState <= ACRS_D_HELD;
         calCnt   <= 32'h0;
         calDone  <= 1'b0;
      end else begin
         pinPrev  <= next_pinPrev;
         devOe    <= next_devOe;
         devState <= next_devState;
         calCnt   <= next_calCnt;
         calDone  <= next_calDone;
      end
   end

   // ----------------------------------------
   // Conversion pipeline
   // ----------------------------------------
   // The output register is the last of the LATENCY stages.
   // The stages keep running during calibration, so live data is valid at once.
   always_comb begin
      next_pipe[0] = sampleIn;
      for (int i = 1; i < LATENCY - 1; i++) begin
         next_pipe[i] = pipe[i-1];
      end
      if (devState != ACRS_D_DONE) begin
         next_dataOut = `ACRS_BUSY_CODE;
      end else begin
         next_dataOut = OW'(pipe[LATENCY-2]);
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         for (int i = 0; i < LATENCY - 1; i++) begin
            pipe[i] <= '0;
         end
         dataOut <= `ACRS_BUSY_CODE;
      end else begin
         for (int i = 0; i < LATENCY - 1; i++) begin
            pipe[i] <= next_pipe[i];
         end
         dataOut <= next_dataOut;
      end
   end

   // ----------------------------------------
   // Output clock
   // ----------------------------------------
   // Preloading the divider means the first edge after release toggles.
   // Ratio one never looks at the pin, as that clock must run through a recal.
   always_comb begin
      half        = acrs_half_count(divSelect);
      next_outClk = outClk;
      next_divCnt = divCnt;
      if ((half != 2'h0) && !pinNow) begin
         next_outClk = 1'b0;
         next_divCnt = half;
      end else if (divCnt >= half) begin
         next_outClk = ~outClk;
         next_divCnt = 2'h0;
      end else begin
         next_divCnt = divCnt + 2'h1;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         outClk <= 1'b0;
         divCnt <= 2'h0;
      end else begin
         outClk <= next_outClk;
         divCnt <= next_divCnt;
      end
   end

   // ----------------------------------------
   // Register read port
   // ----------------------------------------
   // A read answers exactly one cycle after its request; other offsets return
   // zero, so a stray read never looks like a finished calibration.
   always_comb begin
      next_rdAck  = link.regRdReq;
      next_rdData = 8'h00;
      if (link.regRdReq && (link.regAddr == `ACRS_STATUS_OFS)) begin
         next_rdData[`ACRS_CAL_DONE_BIT] = calDone;
      end else if (!link.regRdReq) begin
         next_rdData = rdData;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         rdAck  <= 1'b0;
         rdData <= 8'h00;
      end else begin
         rdAck  <= next_rdAck;
         rdData <= next_rdData;
      end
   end
endmodule // acrs_device
`default_nettype wire

// >>> acrs_host.sv
// Host end: recalibration requests, completion watch, AHB-Lite registers.
`timescale 1ns/100ps
`default_nettype none
`include "acrs_cfg.svh"
module acrs_host
   import acrs_pkg::*;
#(
   parameter int unsigned CAL_MAX   = `ACRS_CAL_MAX_CYC,
   parameter int unsigned PULSE_CYC = `ACRS_PULSE_CYC
) (
   input  wire logic        clk,
   input  wire logic        srst,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output var  logic        hreadyout,
   output var  logic        hresp,
   output var  logic [31:0] hrdata,
   output var  logic        irq,
   acrs_link.host           link
);
   acrs_hstate_t hState;
   acrs_hstate_t next_hState;
   logic [31:0]  timer;
   logic [31:0]  next_timer;
   logic [3:0]   pulseCnt;
   logic [3:0]   next_pulseCnt;
   logic         hostOe;
   logic         next_hostOe;
   logic         rdReq;
   logic         next_rdReq;
   logic         calDone;
   logic         next_calDone;
   logic         calFail;
   logic         next_calFail;
   logic [1:0]   irqStat;
   logic [1:0]   next_irqStat;
   logic [1:0]   irqMask;
   logic [1:0]   next_irqMask;
   logic [1:0]   evt;
   logic [1:0]   clr;
   logic         wrPend;
   logic [7:0]   wrAddr;
   logic [31:0]  next_hrdata;
   logic         pinNow;
   logic         accept;
   logic         recalGo;
   logic         tmo;

   assign link.recalHostOe = hostOe;
   assign link.regRdReq    = rdReq;
   assign link.regAddr     = `ACRS_STATUS_OFS;
   assign accept  = hsel & htrans[1] & hready;
   assign recalGo = wrPend & (wrAddr == `ACRS_REG_CTRL) & hwdata[`ACRS_CTRL_RECAL_BIT];
   assign tmo     = (timer >= 32'(CAL_MAX));

   acrs_sync #(
      .RST_VAL (1'b1)
   ) u_pinSync (
      .clk  (clk),
      .srst (srst),
      .din  (link.recalLevel),
      .dout (pinNow)
   );

   // ----------------------------------------
   // Calibration watch
   // ----------------------------------------
   // No read is sent until the bus leaves the busy code, so power-on
   // calibration sees no register traffic.
   always_comb begin
      next_hState   = hState;
      next_timer    = timer + 32'h1;
      next_pulseCnt = pulseCnt;
      next_hostOe   = 1'b0;
      next_rdReq    = 1'b0;
      next_calDone  = calDone;
      next_calFail  = calFail;
      evt           = 2'b00;
      if (recalGo) begin
         next_hState   = ACRS_H_PULSE;
         next_timer    = 32'h0;
         next_pulseCnt = 4'h0;
         next_hostOe   = 1'b1;
         next_calDone  = 1'b0;
         next_calFail  = 1'b0;
      end else begin
         case (hState)
            ACRS_H_PULSE: begin
               if (pulseCnt == 4'(PULSE_CYC - 1)) begin
                  next_hState = ACRS_H_WATCH;
               end else begin
                  next_pulseCnt = pulseCnt + 4'h1;
                  next_hostOe   = 1'b1;
               end
            end
            ACRS_H_WATCH: begin
               if (tmo) begin
                  next_hState                = ACRS_H_IDLE;
                  next_calFail               = 1'b1;
                  evt[`ACRS_IRQ_FAIL_BIT]    = 1'b1;
               end else if (pinNow && (link.dataOut != `ACRS_BUSY_CODE)) begin
                  next_hState = ACRS_H_ASK;
                  next_rdReq  = 1'b1;
               end
            end
            ACRS_H_ASK: begin
               if (link.regRdAck && link.regRdData[`ACRS_CAL_DONE_BIT]) begin
                  next_hState             = ACRS_H_IDLE;
                  next_calDone            = 1'b1;
                  evt[`ACRS_IRQ_DONE_BIT] = 1'b1;
               end else if (link.regRdAck) begin
                  next_hState = ACRS_H_WATCH;
               end
            end
            default: begin
               next_hState = hState;
            end
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         hState   <= ACRS_H_WATCH;
         timer    <= 32'h0;
         pulseCnt <= 4'h0;
         hostOe   <= 1'b0;
         rdReq    <= 1'b0;
         calDone  <= 1'b0;
         calFail  <= 1'b0;
      end else begin
         hState   <= next_hState;
         timer    <= next_timer;
         pulseCnt <= next_pulseCnt;
         hostOe   <= next_hostOe;
         rdReq    <= next_rdReq;
         calDone  <= next_calDone;
         calFail  <= next_calFail;
      end
   end

   // ----------------------------------------
   // Register slave
   // ----------------------------------------
   // A new event wins over the read that clears its bit.
   always_comb begin
      next_hrdata  = hrdata;
      next_irqMask = irqMask;
      clr          = 2'b00;
      if (wrPend && (wrAddr == `ACRS_REG_IRQ_MASK)) begin
         next_irqMask = hwdata[1:0];
      end
      if (accept && !hwrite) begin
         next_hrdata = 32'h0;
         case (haddr[7:0])
            `ACRS_REG_STATUS: begin
               next_hrdata[`ACRS_ST_DONE_BIT] = calDone;
               next_hrdata[`ACRS_ST_FAIL_BIT] = calFail;
               next_hrdata[`ACRS_ST_BUSY_BIT] = (hState != ACRS_H_IDLE);
               next_hrdata[`ACRS_ST_PIN_BIT]  = pinNow;
            end
            `ACRS_REG_IRQ_STAT: begin
               next_hrdata[1:0] = irqStat;
               clr              = 2'b11;
            end
            `ACRS_REG_IRQ_MASK: begin
               next_hrdata[1:0] = irqMask;
            end
            default: begin
               next_hrdata = 32'h0;
            end
         endcase
      end
      next_irqStat = (irqStat & ~clr) | evt;
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         wrPend    <= 1'b0;
         wrAddr    <= 8'h00;
         hrdata    <= 32'h0;
         irqStat   <= 2'b00;
         irqMask   <= 2'b00;
         irq       <= 1'b0;
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end else begin
         wrPend    <= accept & hwrite;
         wrAddr    <= accept ? haddr[7:0] : wrAddr;
         hrdata    <= next_hrdata;
         irqStat   <= next_irqStat;
         irqMask   <= next_irqMask;
         irq       <= |(next_irqStat & next_irqMask);
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end
   end
endmodule // acrs_host
`default_nettype wire

// >>> acrs_link.sv
// Link between the converter end and its host controller.
`timescale 1ns/100ps
`default_nettype none
`include "acrs_cfg.svh"
interface acrs_link;
   logic                    recalHostOe;
   logic                    recalDevOe;
   logic                    recalLevel;
   logic                    outClk;
   logic [`ACRS_DATA_W-1:0] dataOut;
   logic                    regRdReq;
   logic [7:0]              regAddr;
   logic                    regRdAck;
   logic [7:0]              regRdData;
   // Open-drain pin with pull-up: low whenever either side drives.
   assign recalLevel = ~(recalHostOe | recalDevOe);
   modport dev (
      output recalDevOe,
      output outClk,
      output dataOut,
      output regRdAck,
      output regRdData,
      input  recalLevel,
      input  regRdReq,
      input  regAddr
   );
   modport host (
      output recalHostOe,
      output regRdReq,
      output regAddr,
      input  recalLevel,
      input  outClk,
      input  dataOut,
      input  regRdAck,
      input  regRdData
   );
endinterface
`default_nettype wire

// >>> acrs_pkg.sv
// Types shared by both ends of the calibration reset sequencer.
`default_nettype none
package acrs_pkg;
   typedef enum logic [1:0] {
      ACRS_DIV_1 = 2'b00,
      ACRS_DIV_2 = 2'b01,
      ACRS_DIV_4 = 2'b10
   } acrs_div_t;
   typedef enum logic [1:0] {
      ACRS_D_HELD = 2'b00,
      ACRS_D_CAL  = 2'b01,
      ACRS_D_DONE = 2'b10
   } acrs_dstate_t;
   typedef enum logic [2:0] {
      ACRS_H_IDLE  = 3'b000,
      ACRS_H_PULSE = 3'b001,
      ACRS_H_WATCH = 3'b010,
      ACRS_H_ASK   = 3'b011
   } acrs_hstate_t;
   // Edges per output clock half period, minus one.
   function automatic logic [1:0] acrs_half_count(input acrs_div_t div);
      case (div)
         ACRS_DIV_2: acrs_half_count = 2'h1;
         ACRS_DIV_4: acrs_half_count = 2'h3;
         default:    acrs_half_count = 2'h0;
      endcase
   endfunction
endpackage
`default_nettype wire

// >>> acrs_sync.sv
// Three-stage pin synchroniser with agreement filter.
`timescale 1ns/100ps
`default_nettype none
module acrs_sync #(
   parameter logic RST_VAL = 1'b1
) (
   input  wire logic clk,
   input  wire logic srst,
   input  wire logic din,
   output var  logic dout
);
   logic ff1;
   logic ff2;
   logic ff3;
   logic next_dout;

   // A change counts only once the second and third stages agree.
   always_comb begin
      next_dout = dout;
      if (ff2 == ff3) begin
         next_dout = ff3;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         ff1  <= RST_VAL;
         ff2  <= RST_VAL;
         ff3  <= RST_VAL;
         dout <= RST_VAL;
      end else begin
         ff1  <= din;
         ff2  <= ff1;
         ff3  <= ff2;
         dout <= next_dout;
      end
   end
endmodule // acrs_sync
`default_nettype wire

// >>> tb_adc_calibration_reset_sequencer.sv
// Self-checking bench joining the converter end and the host controller.
`timescale 1ns/100ps
`default_nettype none
module tb_adc_calibration_reset_sequencer
   import acrs_pkg::*;
;
   logic        clk = 1'b0;
   logic        srst = 1'b1;
   logic        porActive = 1'b1;
   logic [13:0] sampleIn = 14'h0;
   acrs_div_t   divSelect = ACRS_DIV_2;
   logic        hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0]  htrans = 2'h0;
   logic        hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0;
   logic        hready;
   logic        hresp;
   logic [31:0] hrdata;
   logic        irq;
   logic [31:0] rd;
   logic        prevClk;
   int          n_mismatch = 0;
   int          n_tests = 0;
   int          cyc = 0;
   acrs_link lnk ();
   acrs_device #(.CAL_CYCLES(50)) i_acrs_device (
      .clk(clk), .srst(srst), .porActive(porActive), .sampleIn(sampleIn),
      .divSelect(divSelect), .link(lnk.dev)
   );
   acrs_host #(.CAL_MAX(400), .PULSE_CYC(4)) i_acrs_host (
      .clk(clk), .srst(srst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
      .hreadyout(hready), .hresp(hresp), .hrdata(hrdata), .irq(irq), .link(lnk.host)
   );
   acrs_chk i_acrs_chk (
      .clk(clk), .srst(srst), .porActive(porActive), .sampleIn(sampleIn),
      .divSelect(divSelect), .recalHostOe(lnk.recalHostOe), .recalDevOe(lnk.recalDevOe),
      .recalLevel(lnk.recalLevel), .outClk(lnk.outClk), .dataOut(lnk.dataOut),
      .regRdReq(lnk.regRdReq), .regAddr(lnk.regAddr), .regRdAck(lnk.regRdAck),
      .regRdData(lnk.regRdData)
   );
   // ----------------------------------------
   // Clock, samples and hang guard
   // ----------------------------------------
   initial begin
      forever #12.5 clk = ~clk;
   end
   always @(posedge clk) begin
      sampleIn <= sampleIn + 14'h1;
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         n_mismatch++;
         print_verdict();
      end
   end
   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      n_tests++;
      if (got !== exp) begin
         n_mismatch++;
         $display("MISMATCH %s expected %h seen %h", name, exp, got);
      end
   endtask
   // Single AHB-Lite transfer; read data lands in rd.
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      htrans <= 2'b10;
      hwrite <= wr;
      do @(posedge clk); while (hready !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      do @(posedge clk); while (hready !== 1'b1);
      rd = hrdata;
   endtask
   task automatic wait_irq(input int lim);
      int k;
      k = 0;
      while (irq !== 1'b1 && k < lim) begin
         @(posedge clk);
         k++;
      end
   endtask
   task automatic print_verdict();
      if (n_mismatch == 0 && n_tests > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      repeat (10) @(posedge clk);
      srst <= 1'b0;
      repeat (20) @(posedge clk);
      chk("pinPor", 32'h0, lnk.recalLevel);
      chk("clkHeld2", 32'h0, lnk.outClk);
      chk("dataPor", 32'hcccc, lnk.dataOut);
      bus(1'b1, 8'h0c, 32'h1);
      porActive <= 1'b0;
      repeat (40) @(posedge clk);
      chk("calCode", 32'hcccc, lnk.dataOut);
      wait_irq(300);
      chk("irqDone", 32'h1, irq);
      chk("latency", {18'h0, sampleIn - 14'd10}, {16'h0, lnk.dataOut});
      bus(1'b0, 8'h04, 32'h0);
      chk("status", 32'h9, rd);
      bus(1'b0, 8'h08, 32'h0);
      chk("irqStat", 32'h1, rd);
      repeat (2) @(posedge clk);
      chk("irqClear", 32'h0, irq);
      // Recalibration with ratio one: the output clock must keep running.
      divSelect <= ACRS_DIV_1;
      repeat (4) @(posedge clk);
      bus(1'b1, 8'h00, 32'h1);
      @(posedge clk);
      chk("pinPulse", 32'h0, lnk.recalLevel);
      prevClk = lnk.outClk;
      @(posedge clk);
      chk("clkRun1", {31'h0, ~prevClk}, lnk.outClk);
      bus(1'b0, 8'h04, 32'h0);
      chk("busy", 32'h1, rd[2]);
      repeat (20) @(posedge clk);
      chk("recalCode", 32'hcccc, lnk.dataOut);
      wait_irq(300);
      bus(1'b0, 8'h08, 32'h0);
      chk("irqRecal", 32'h1, rd);
      // Device held in power-on with ratio four; the host must give up at its limit.
      divSelect <= ACRS_DIV_4;
      porActive <= 1'b1;
      repeat (10) @(posedge clk);
      chk("clkHeld4", 32'h0, lnk.outClk);
      bus(1'b1, 8'h00, 32'h1);
      repeat (370) @(posedge clk);
      bus(1'b0, 8'h04, 32'h0);
      chk("noFailYet", 32'h0, rd[1]);
      repeat (40) @(posedge clk);
      bus(1'b0, 8'h04, 32'h0);
      chk("failSet", 32'h1, rd[1]);
      chk("irqMasked", 32'h0, irq);
      bus(1'b1, 8'h0c, 32'h3);
      repeat (2) @(posedge clk);
      chk("irqUnmask", 32'h1, irq);
      bus(1'b0, 8'h08, 32'h0);
      chk("irqFail", 32'h2, rd);
      bus(1'b0, 8'h0c, 32'h0);
      chk("irqMaskRd", 32'h3, rd);
      chk("hresp", 32'h0, hresp);
      // Unmapped place and write-only control word both read as zero.
      bus(1'b1, 8'h10, 32'hffffffff);
      bus(1'b0, 8'h10, 32'h0);
      chk("unmapped", 32'h0, rd);
      bus(1'b0, 8'h00, 32'h0);
      chk("ctrlRead", 32'h0, rd);
      porActive <= 1'b0;
      repeat (100) @(posedge clk);
      chk("latency4", {18'h0, sampleIn - 14'd10}, {16'h0, lnk.dataOut});
      print_verdict();
   end
endmodule // tb_adc_calibration_reset_sequencer
`default_nettype wire
